/* File: logic/cdrv_ctrl.sv */
/*
 can output driver control: output_driver_config, test register,
 transmit buffer bytes and the drive of both transmit pins.
 assumes a byte register window, tx_bit and bit_start from the
 bit engine, synchronous to mclk; pin pads resolve out/oe.
*/
`timescale 1ns/100ps
`include "cdrv_params.svh"
module cdrv_ctrl (
   input wire logic mclk, // controller clock
   input wire logic rst_b, // synchronous reset, low
   input wire logic cfg_hold, // config_hold_bit (reset request)
   input wire logic sleep, // controller sleep mode
   input wire logic tx_bit, // serial bit to send, 0 dominant
   input wire logic bit_start, // pulse at each bit period start
   input wire cdrv_pkg::cdrv_presc_t presc, // prescaler field
   input wire logic rx_comparator_out, // input comparator
   input wire logic reg_wr, // register write strobe
   input wire logic reg_rd, // register read strobe
   input wire cdrv_pkg::cdrv_byte_t reg_addr, // register offset
   input wire cdrv_pkg::cdrv_byte_t reg_wdata, // write data
   output cdrv_pkg::cdrv_byte_t reg_rdata, // read data
   output logic tx_pin_a_out, // tx_pin_a level
   output logic tx_pin_a_oe, // tx_pin_a driven
   output logic tx_pin_b_out, // tx_pin_b level
   output logic tx_pin_b_oe, // tx_pin_b driven
   output logic hs_sw_a_q, // high_side_switch pin a
   output logic ls_sw_a_q, // low_side_switch pin a
   output logic hs_sw_b_q, // high_side_switch pin b
   output logic ls_sw_b_q // low_side_switch pin b
);
   import cdrv_pkg::*;
   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   cdrv_byte_t ocr_q; // output_driver_config
   cdrv_byte_t test_q; // production_test_control
   cdrv_byte_t buf_q [`CDRV_BUF_BYTES]; // descriptor then data
   cdrv_mode_t mode; // output_mode_sel
   logic sel_b_q; // pin b holds the turn between bit starts
   logic turn_b; // pin b holds the turn in this cycle
   logic dom_q; // bit in progress is dominant
   logic tx_clk; // tx_bit_clock
   logic data_a; // bit for pin a
   logic data_b; // bit for pin b
   logic off_a; // pin a switches forced off
   logic off_b; // pin b switches forced off
   logic hs_a; // decoded switches
   logic ls_a;
   logic hs_b;
   logic ls_b;
   // byte index within the transmit buffer
   function automatic logic [3:0] buf_idx(input cdrv_byte_t a);
      cdrv_byte_t d;
      d = a - `CDRV_OFS_BUF_LO;
      return d[3:0];
   endfunction
   // address falls inside the transmit buffer
   function automatic logic is_buf(input cdrv_byte_t a);
      return (a >= `CDRV_OFS_BUF_LO) && (a <= `CDRV_OFS_BUF_HI);
   endfunction
   assign mode = {ocr_q[`CDRV_MODE_HI], ocr_q[`CDRV_MODE_LO]};
   // ----------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------
   // config only moves under hold so the pins never glitch mid-frame
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         ocr_q <= `CDRV_OCR_RST;
      end else if (reg_wr && cfg_hold && reg_addr == `CDRV_OFS_OCR) begin
         ocr_q <= reg_wdata;
      end
   end
   // reserved top bits never store
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         test_q <= `CDRV_TEST_RST;
      end else if (reg_wr && reg_addr == `CDRV_OFS_TEST) begin
         test_q <= reg_wdata & `CDRV_TEST_WMASK;
      end
   end
   // buffer bytes, written by the processor at any time
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         for (int i = 0; i < `CDRV_BUF_BYTES; i++) begin
            buf_q[i] <= 8'h00;
         end
      end else if (reg_wr && is_buf(reg_addr)) begin
         buf_q[buf_idx(reg_addr)] <= reg_wdata;
      end
   end
   // ----------------------------------------------------------------
   // register reads
   // ----------------------------------------------------------------
   // data appears the edge after the read strobe
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         if (reg_addr == `CDRV_OFS_OCR) begin
            reg_rdata <= cfg_hold ? ocr_q : 8'h00;
         end else if (reg_addr == `CDRV_OFS_TEST) begin
            reg_rdata <= test_q;
         end else if (is_buf(reg_addr)) begin
            reg_rdata <= buf_q[buf_idx(reg_addr)];
         end else begin
            reg_rdata <= 8'h00; // unmapped
         end
      end
   end
   // ----------------------------------------------------------------
   // bi-phase alternation
   // ----------------------------------------------------------------
   // flips when a dominant bit ends; recessive gaps keep the turn
   always_ff @(posedge mclk) begin
      if (!rst_b || cfg_hold || mode != `CDRV_MODE_BIPH) begin
         sel_b_q <= 1'b0;
         dom_q <= 1'b0;
      end else if (bit_start) begin
         dom_q <= !tx_bit;
         if (dom_q) begin
            sel_b_q <= !sel_b_q;
         end
      end
   end
   // turn passes at the bit start itself, so a new dominant bit
   // never spends its first cycle on the pin that sent the last one
   assign turn_b = sel_b_q ^ (bit_start && dom_q);
   // ----------------------------------------------------------------
   // bit clock and pin data selection
   // ----------------------------------------------------------------
   cdrv_tqclk u_tqclk (
      .mclk(mclk),
      .rst_b(rst_b),
      .presc(presc),
      .bit_start(bit_start),
      .clk_hi(tx_clk)
   );
   // the test float bit lets production floats the drivers
   always_comb begin
      data_a = tx_bit;
      data_b = tx_bit;
      off_a = 1'b0;
      off_b = 1'b0;
      unique case (mode)
         `CDRV_MODE_NORM: begin
            data_b = tx_bit;
         end
         `CDRV_MODE_CLK: begin
            data_b = tx_clk;
         end
         `CDRV_MODE_TEST: begin
            data_b = rx_comparator_out;
         end
         `CDRV_MODE_BIPH: begin
            off_a = tx_bit || turn_b;
            off_b = tx_bit || !turn_b;
         end
      endcase
      if (sleep) begin
         data_a = 1'b1;
         data_b = 1'b1;
         off_a = 1'b0;
         off_b = 1'b0;
      end
      if (cfg_hold || test_q[`CDRV_TEST_FLOAT]) begin
         off_a = 1'b1;
         off_b = 1'b1;
      end
   end
   cdrv_pin u_pin_a (
      .hs_en(ocr_q[`CDRV_HS_A]),
      .ls_en(ocr_q[`CDRV_LS_A]),
      .pol(ocr_q[`CDRV_POL_A]),
      .data(data_a),
      .off(off_a),
      .hs_sw(hs_a),
      .ls_sw(ls_a)
   );
   cdrv_pin u_pin_b (
      .hs_en(ocr_q[`CDRV_HS_B]),
      .ls_en(ocr_q[`CDRV_LS_B]),
      .pol(ocr_q[`CDRV_POL_B]),
      .data(data_b),
      .off(off_b),
      .hs_sw(hs_b),
      .ls_sw(ls_b)
   );
   // ----------------------------------------------------------------
   // pin registers
   // ----------------------------------------------------------------
   // a pin with no switch on is released, never driven
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         hs_sw_a_q <= 1'b0;
         ls_sw_a_q <= 1'b0;
         hs_sw_b_q <= 1'b0;
         ls_sw_b_q <= 1'b0;
         tx_pin_a_out <= 1'b0;
         tx_pin_a_oe <= 1'b0;
         tx_pin_b_out <= 1'b0;
         tx_pin_b_oe <= 1'b0;
      end else begin
         hs_sw_a_q <= hs_a;
         ls_sw_a_q <= ls_a;
         hs_sw_b_q <= hs_b;
         ls_sw_b_q <= ls_b;
         tx_pin_a_out <= hs_a;
         tx_pin_a_oe <= hs_a || ls_a;
         tx_pin_b_out <= hs_b;
         tx_pin_b_oe <= hs_b || ls_b;
      end
   end
   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   logic [7:0] hi_len_q; // length of the running clock pulse
   always_ff @(posedge mclk) begin
      // a restart counts the new pulse from zero as well
      if (!rst_b || !tx_clk || bit_start) begin
         hi_len_q <= 8'h00;
      end else begin
         hi_len_q <= hi_len_q + 8'h01;
      end
   end
   sequence s_buf_wr;
      reg_wr && is_buf(reg_addr);
   endsequence
   sequence s_buf_rd_same;
      reg_rd && !reg_wr && reg_addr == $past(reg_addr);
   endsequence
   a_ocr_locked: assert property (@(posedge mclk) disable iff (!rst_b)
      !cfg_hold |=> $stable(ocr_q))
      else $error("config changed outside hold");
   a_hold_float: assert property (@(posedge mclk) disable iff (!rst_b)
      cfg_hold |=> !tx_pin_a_oe && !tx_pin_b_oe && !hs_sw_a_q && !ls_sw_b_q)
      else $error("driver active under hold");
   a_sleep_recess: assert property (@(posedge mclk) disable iff (!rst_b)
      (sleep && !cfg_hold && !test_q[`CDRV_TEST_FLOAT]) |=>
      hs_sw_a_q == (ocr_q[`CDRV_HS_A] && !ocr_q[`CDRV_POL_A]) &&
      ls_sw_b_q == (ocr_q[`CDRV_LS_B] && ocr_q[`CDRV_POL_B]))
      else $error("sleep not recessive");
   a_norm_drive: assert property (@(posedge mclk) disable iff (!rst_b)
      (mode == `CDRV_MODE_NORM && !cfg_hold && !sleep && !test_q[0]) |=>
      hs_sw_b_q == ($past(ocr_q[`CDRV_HS_B]) &&
      ($past(tx_bit) ^ $past(ocr_q[`CDRV_POL_B]))))
      else $error("normal mode switch wrong");
   a_float_oe: assert property (@(posedge mclk) disable iff (!rst_b)
      tx_pin_a_oe == (hs_sw_a_q || ls_sw_a_q) && !(hs_sw_b_q && ls_sw_b_q))
      else $error("float pin driven");
   a_clk_rise: assert property (@(posedge mclk) disable iff (!rst_b)
      bit_start |=> tx_clk && hi_len_q == 8'h00)
      else $error("bit clock not restarted");
   a_clk_width: assert property (@(posedge mclk) disable iff (!rst_b)
      ($fell(tx_clk) && !$past(bit_start) && $stable(presc)) |->
      hi_len_q == {1'b0, presc, 1'b1} + 8'h01 && $past(hi_len_q) == {1'b0, presc, 1'b1})
      else $error("bit clock width wrong");
   a_biph_recess: assert property (@(posedge mclk) disable iff (!rst_b)
      (mode == `CDRV_MODE_BIPH && tx_bit && !sleep) |=>
      !tx_pin_a_oe && !tx_pin_b_oe)
      else $error("bi-phase recessive driven");
   a_biph_alt: assert property (@(posedge mclk) disable iff (!rst_b)
      (mode == `CDRV_MODE_BIPH && !cfg_hold && bit_start && dom_q) |=>
      sel_b_q != $past(sel_b_q))
      else $error("bi-phase turn not passed");
   a_buf_rdback: assert property (@(posedge mclk) disable iff (!rst_b)
      (s_buf_wr ##1 s_buf_rd_same) |=>
      reg_rdata == $past(reg_wdata, 2))
      else $error("buffer byte not read back");
endmodule // cdrv_ctrl

/* File: logic/cdrv_params.svh */
/*
 constants of the can output driver control block: offsets, field
 positions, reset values and codes. assumes inclusion by bare name.
*/
`ifndef CDRV_PARAMS_SVH
`define CDRV_PARAMS_SVH
// ----------------------------------------------------------------
// register window offsets
// ----------------------------------------------------------------
`define CDRV_OFS_OCR 8'h08
`define CDRV_OFS_TEST 8'h09
`define CDRV_OFS_BUF_LO 8'h0a
`define CDRV_OFS_BUF_HI 8'h13
`define CDRV_BUF_BYTES 10
// ----------------------------------------------------------------
// output_driver_config field positions
// ----------------------------------------------------------------
`define CDRV_HS_B 7
`define CDRV_LS_B 6
`define CDRV_POL_B 5
`define CDRV_HS_A 4
`define CDRV_LS_A 3
`define CDRV_POL_A 2
`define CDRV_MODE_HI 1
`define CDRV_MODE_LO 0
// ----------------------------------------------------------------
// production_test_control fields and reset values
// ----------------------------------------------------------------
`define CDRV_TEST_FLOAT 0
`define CDRV_TEST_WMASK 8'h3f
`define CDRV_OCR_RST 8'h00
`define CDRV_TEST_RST 8'h00
// ----------------------------------------------------------------
// output mode codes
// ----------------------------------------------------------------
`define CDRV_MODE_BIPH 2'h0
`define CDRV_MODE_TEST 2'h1
`define CDRV_MODE_NORM 2'h2
`define CDRV_MODE_CLK 2'h3
`endif

/* File: logic/cdrv_pkg.sv */
/*
 types shared by the output driver control files.
 assumes cdrv_params.svh is visible in the same compile.
*/
package cdrv_pkg;
   typedef logic [7:0] cdrv_byte_t; // one register byte
   typedef logic [5:0] cdrv_presc_t; // prescaler field
   typedef logic [1:0] cdrv_mode_t; // output mode code
   typedef logic [6:0] cdrv_tqcnt_t; // mclk count within a tq
endpackage

/* File: logic/cdrv_pin.sv */
/*
 switch decode of one transmit pin from drive type, polarity and data.
 assumes the caller registers the result.
*/
`timescale 1ns/100ps
module cdrv_pin (
   input wire logic hs_en, // high_side_enable
   input wire logic ls_en, // low_side_enable
   input wire logic pol, // output_polarity
   input wire logic data, // bit to send
   input wire logic off, // force all switches off
   output logic hs_sw, // high_side_switch
   output logic ls_sw // low_side_switch
);
   // ----------------------------------------------------------------
   // switch decode
   // ----------------------------------------------------------------
   // both switches can never be on together: data^pol selects one
   always_comb begin
      hs_sw = !off && hs_en && ((data ^ pol) == 1'b1);
      ls_sw = !off && ls_en && ((data ^ pol) == 1'b0);
   end
endmodule // cdrv_pin

/* File: logic/cdrv_tqclk.sv */
/*
 time quantum divider and transmit bit clock.
 assumes bit_start is a one-cycle pulse at each bit period start.
*/
`timescale 1ns/100ps
module cdrv_tqclk (
   input wire logic mclk, // controller clock
   input wire logic rst_b, // synchronous reset, low
   input wire cdrv_pkg::cdrv_presc_t presc, // prescaler field
   input wire logic bit_start, // bit period starts
   output logic clk_hi // tx_bit_clock, high one tq
);
   import cdrv_pkg::*;
   cdrv_tqcnt_t cnt_q; // mclk cycles into the high pulse
   cdrv_tqcnt_t last; // final count of one tq
   // ----------------------------------------------------------------
   // high pulse timing
   // ----------------------------------------------------------------
   // one tq is 2*(presc+1) mclk periods
   assign last = cdrv_tqcnt_t'({presc, 1'b1});
   // restart on every bit start so the rising edge marks it
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         cnt_q <= '0;
         clk_hi <= 1'b0;
      end else if (bit_start) begin
         cnt_q <= '0;
         clk_hi <= 1'b1;
      end else if (clk_hi) begin
         cnt_q <= cnt_q + 7'h01;
         if (cnt_q == last) begin
            clk_hi <= 1'b0;
         end
      end
   end
endmodule // cdrv_tqclk

/* File: tb/cdrv_bus_model.sv */
/*
 bus transceiver model that both transmit pins of the controller drive.
 assumes pin level/enable pairs from the controller, and a flip input
 from the bench that stands for a faulty receive comparator.
*/
`timescale 1ns/100ps
module cdrv_bus_model (
   input wire logic tx_pin_a_out, // pin a level
   input wire logic tx_pin_a_oe, // pin a driven
   input wire logic tx_pin_b_out, // pin b level
   input wire logic tx_pin_b_oe, // pin b driven
   input wire logic flip, // comparator fault, inverts reading
   output logic bus_lvl, // resolved bus, low is dominant
   output logic rx_comparator_out // comparator back to controller
);
   // ----------------------------------------------------------------
   // wire resolution
   // ----------------------------------------------------------------
   // a floating pin falls to the pull-up, i.e. the recessive level
   assign bus_lvl = (tx_pin_a_oe ? tx_pin_a_out : 1'h1) & (tx_pin_b_oe ? tx_pin_b_out : 1'h1);
   // low on the wire reads dominant only when settings
   assign rx_comparator_out = bus_lvl ^ flip;
endmodule // cdrv_bus_model

/* File: tb/tb.sv */
/*
 self-checking bench of cdrv_ctrl with the bus model on both pins.
 assumes the design files and cdrv_params.svh in the same compile.
*/
`timescale 1ns/100ps
`include "cdrv_params.svh"
module tb;
   import cdrv_pkg::*;
   // ----------------------------------------------------------------
   // signals and counters
   // ----------------------------------------------------------------
   logic mclk = 1'h0;
   logic rst_b = 1'h0; // held low for the first cycles
   logic cfg_hold = 1'h0;
   logic sleep = 1'h0;
   logic tx_bit = 1'h1; // recessive while idle
   logic bit_start = 1'h0;
   cdrv_presc_t presc = 6'h00;
   logic reg_wr = 1'h0;
   logic reg_rd = 1'h0;
   cdrv_byte_t reg_addr = 8'h00;
   cdrv_byte_t reg_wdata = 8'h00;
   cdrv_byte_t reg_rdata;
   logic flip = 1'h0; // comparator fault request
   logic rx_cmp, bus_lvl;
   logic tx_pin_a_out, tx_pin_a_oe, tx_pin_b_out, tx_pin_b_oe;
   logic hs_sw_a_q, ls_sw_a_q, hs_sw_b_q, ls_sw_b_q;
   int err_total = 0;
   int total_checks = 0;
   int cycles = 0;
   logic [9:0] clk_seen;
   // normal mode rows: config, bit, {hs_b, ls_b, hs_a, ls_a}
   cdrv_byte_t row_ocr [8] = '{8'h22, 8'h06, 8'h6a, 8'h4e, 8'hb2, 8'h96, 8'hfa, 8'hde};
   logic row_txb [8] = '{1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1};
   logic [3:0] row_exp [8] = '{4'h0, 4'h0, 4'h1, 4'h1, 4'h8, 4'h8, 4'h9, 4'h9};
   // bi-phase bit train and the switch pattern each bit gives
   logic bp_bit [6] = '{1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0};
   logic [3:0] bp_exp [6] = '{4'h1, 4'h0, 4'h4, 4'h1, 4'h0, 4'h4};
   // ----------------------------------------------------------------
   // design and far side
   // ----------------------------------------------------------------
   cdrv_ctrl dut (.mclk(mclk), .rst_b(rst_b), .cfg_hold(cfg_hold), .sleep(sleep),
      .tx_bit(tx_bit), .bit_start(bit_start), .presc(presc), .rx_comparator_out(rx_cmp),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .tx_pin_a_out(tx_pin_a_out), .tx_pin_a_oe(tx_pin_a_oe),
      .tx_pin_b_out(tx_pin_b_out), .tx_pin_b_oe(tx_pin_b_oe), .hs_sw_a_q(hs_sw_a_q),
      .ls_sw_a_q(ls_sw_a_q), .hs_sw_b_q(hs_sw_b_q), .ls_sw_b_q(ls_sw_b_q));
   cdrv_bus_model bus_model_i (.tx_pin_a_out(tx_pin_a_out), .tx_pin_a_oe(tx_pin_a_oe),
      .tx_pin_b_out(tx_pin_b_out), .tx_pin_b_oe(tx_pin_b_oe), .flip(flip),
      .bus_lvl(bus_lvl), .rx_comparator_out(rx_cmp));
   // ----------------------------------------------------------------
   // clock and watchdog
   // ----------------------------------------------------------------
   initial begin
      forever #50 mclk = ~mclk;
   end
   // run needs about 220 cycles; ceiling leaves wide margin
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         err_total++;
         stop_test();
      end
   end
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   // inputs always change 10 ns after the rising edge
   task automatic step;
      @(posedge mclk);
      #10;
   endtask
   task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // switches, then pin level/enable derived from them
   task automatic chk_sw(input string nm, input logic [3:0] e);
      chk(nm, {6'h0, e}, {6'h0, hs_sw_b_q, ls_sw_b_q, hs_sw_a_q, ls_sw_a_q});
      chk(nm, {6'h0, e[3] | e[2], e[3], e[1] | e[0], e[1]},
         {6'h0, tx_pin_b_oe, tx_pin_b_out, tx_pin_a_oe, tx_pin_a_out});
   endtask
   // strobe drops with an idle cycle, so calls never collide
   task automatic wr(input cdrv_byte_t a, input cdrv_byte_t d);
      reg_wr = 1'h1;
      reg_addr = a;
      reg_wdata = d;
      step;
      reg_wr = 1'h0;
      step;
   endtask
   task automatic rd(input string nm, input cdrv_byte_t a, input cdrv_byte_t e);
      reg_rd = 1'h1;
      reg_addr = a;
      step;
      reg_rd = 1'h0;
      step;
      chk(nm, {2'h0, e}, {2'h0, reg_rdata});
   endtask
   // config may only be loaded under hold
   task automatic cfg(input cdrv_byte_t d);
      cfg_hold = 1'h1;
      wr(`CDRV_OFS_OCR, d);
      cfg_hold = 1'h0;
      repeat (2) step;
   endtask
   task automatic send(input logic b);
      tx_bit = b;
      bit_start = 1'h1;
      step;
      bit_start = 1'h0;
      repeat (3) step;
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (4) step;
      rst_b = 1'h1;
      step;
      chk_sw("reset pins", 4'h0);
      cfg_hold = 1'h1;
      rd("config reset", `CDRV_OFS_OCR, 8'h00);
      rd("test reset", `CDRV_OFS_TEST, 8'h00);
      wr(`CDRV_OFS_OCR, 8'ha5);
      rd("config held", `CDRV_OFS_OCR, 8'ha5);
      cfg_hold = 1'h0;
      wr(`CDRV_OFS_OCR, 8'h3c);
      rd("config unheld", `CDRV_OFS_OCR, 8'h00);
      cfg_hold = 1'h1;
      rd("config kept", `CDRV_OFS_OCR, 8'ha5);
      cfg_hold = 1'h0;
      wr(`CDRV_OFS_TEST, 8'hff);
      rd("test reserved", `CDRV_OFS_TEST, 8'h3f);
      wr(`CDRV_OFS_TEST, 8'h00);
      // fill descriptor and data bytes, then read all back
      for (int i = 0; i < `CDRV_BUF_BYTES; i++) wr(`CDRV_OFS_BUF_LO + 8'(i), 8'hc3 ^ 8'(i));
      for (int i = 0; i < `CDRV_BUF_BYTES; i++) begin
         rd("buffer", `CDRV_OFS_BUF_LO + 8'(i), 8'hc3 ^ 8'(i));
      end
      wr(8'h14, 8'hff);
      rd("unmapped", 8'h14, 8'h00);
      // write then read the same byte on the very next edge
      reg_wr = 1'h1;
      reg_addr = 8'h0c;
      reg_wdata = 8'h5a;
      step;
      reg_wr = 1'h0;
      reg_rd = 1'h1;
      step;
      reg_rd = 1'h0;
      step;
      chk("buffer back to back", 10'h05a, {2'h0, reg_rdata});
      // normal mode drive table
      for (int i = 0; i < 8; i++) begin
         cfg(row_ocr[i]);
         send(row_txb[i]);
         chk_sw("normal row", row_exp[i]);
      end
      // push-pull, polarity 0: dominant low on tx_bit 0
      cfg(8'hda);
      send(1'h0);
      chk_sw("dominant", 4'h5);
      chk("bus level", 10'h000, {9'h000, bus_lvl});
      sleep = 1'h1;
      repeat (2) step;
      chk_sw("sleep", 4'ha);
      cfg_hold = 1'h1;
      repeat (2) step;
      chk_sw("hold over sleep", 4'h0);
      cfg_hold = 1'h0;
      sleep = 1'h0;
      wr(`CDRV_OFS_TEST, 8'h01);
      chk_sw("test float", 4'h0);
      wr(`CDRV_OFS_TEST, 8'h00);
      chk_sw("test idle", 4'h5);
      // clock mode: high for 2*(presc+1) cycles from bit start
      cfg(8'hdb);
      for (int p = 0; p < 3; p += 2) begin
         presc = 6'(p);
         step;
         bit_start = 1'h1;
         step;
         bit_start = 1'h0;
         for (int i = 0; i < 10; i++) begin
            step;
            clk_seen[i] = hs_sw_b_q;
         end
         chk("bit clock", (10'h1 << (2 * (p + 1))) - 10'h1, clk_seen);
         chk_sw("clock idle", 4'h5);
      end
      // bi-phase: recessive floats, dominant alternates a, b, a, b
      tx_bit = 1'h1;
      cfg(8'hd8);
      for (int i = 0; i < 6; i++) begin
         send(bp_bit[i]);
         chk_sw("bi-phase", bp_exp[i]);
      end
      // test mode: pin b follows the comparator, fault shows
      cfg(8'hd9);
      send(1'h0);
      flip = 1'h1;
      repeat (3) step;
      chk_sw("test mode flip", 4'h9);
      flip = 1'h0;
      repeat (3) step;
      chk_sw("test mode", 4'h5);
      stop_test();
   end
endmodule // tb
